// File: core/emm_mode_ctrl.sv
// MAC mode-control register with its status and interrupt logic, the
// receive and transmit enable gating and the link-side sampling.
// Assumes an AHB-Lite master, an MII PHY whose pins and receive clock are
// asynchronous, and transmit/receive datapaths on sys_clk.
`timescale 1ns/100ps

module emm_mode_ctrl
  import emm_pkg::*;
#(
  parameter int CNT_W = EMM_CNT_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // MII receive pins and PHY status, asynchronous
  input wire logic mii_rx_clk,
  input wire logic mii_rx_dv,
  input wire logic mii_rx_er,
  input wire logic [3:0] mii_rxd,
  input wire logic mii_col,
  input wire logic link_status,
  // Transmit datapath, on sys_clk
  input wire logic tx_frame_req,
  input wire logic tx_frame_done,
  input wire logic tx_nib_stb,
  input wire logic tx_en_in,
  input wire logic [3:0] txd_in,
  // Receive datapath events, on sys_clk
  input wire logic rx_crc_err,
  input wire logic wake_pattern_seen,
  input wire logic rx_filter_valid,
  input wire logic rx_addr_match,
  input wire logic rx_bcast_hit,
  input wire logic rx_mcast_hit,
  // Receive nibble stream to the datapath
  output logic rx_nib_valid,
  output logic [3:0] rx_nib,
  output logic rx_nib_err,
  // Mode outputs
  output logic rx_run,
  output logic tx_run,
  output logic full_duplex,
  output logic tx_collision,
  output logic rx_accept,
  output logic rx_crc_fault,
  // Pins and interrupt
  output logic general_output_pin,
  output logic wake_on_lan_output,
  output logic irq
);

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  logic [31:0] mode;
  logic [EMM_ST_W-1:0] status;
  logic [EMM_ST_W-1:0] int_en;
  logic [CNT_W-1:0] crc_cnt;
  logic wr_pend;
  logic [7:0] wr_ofs;
  logic rx_in_frame;
  logic tx_in_frame;
  logic rx_clk_prev;
  logic link_prev;
  logic [EMM_LINK_SETTLE-1:0] link_warm;
  logic [EMM_SYNC_W-1:0] pins_s;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Widens a status-layout field to a bus word; reserved bits read as zero
  function automatic logic [31:0] st_word(input logic [EMM_ST_W-1:0] val);
    st_word = {{(32-EMM_ST_W){1'b0}}, val};
  endfunction

  // Matches a bus offset against one register's offset
  function automatic logic ofs_hit(input logic [7:0] ofs, input logic [7:0] reg_ofs);
    ofs_hit = (ofs == reg_ofs);
  endfunction

  // ------------------------------------------------------------------
  // Link pin synchronisation
  // ------------------------------------------------------------------
  emm_sync #(
    .WIDTH(EMM_SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({mii_rx_clk, mii_rx_dv, mii_rx_er, mii_rxd, mii_col, link_status}),
    .sync_out(pins_s)
  );

  wire s_rx_clk = pins_s[8];
  wire s_rx_dv = pins_s[7];
  wire s_rx_er = pins_s[6];
  wire [3:0] s_rxd = pins_s[5:2];
  wire s_col = pins_s[1];
  wire s_link = pins_s[0];

  // ------------------------------------------------------------------
  // Mode field decode
  // ------------------------------------------------------------------
  wire m_promisc = mode[EMM_B_PROMISC];
  wire m_duplex = mode[EMM_B_DUPLEX];
  wire m_int_loop = mode[EMM_B_INT_LOOP];
  wire m_tx_en = mode[EMM_B_TX_EN];
  wire m_rx_en = mode[EMM_B_RX_EN];
  wire m_wake_en = mode[EMM_B_WAKE_EN];
  wire m_crc_permit = mode[EMM_B_CRC_PERMIT];

  // ------------------------------------------------------------------
  // Receive source selection
  // ------------------------------------------------------------------
  // Rising edge of the sampled receive clock marks one nibble
  // Data and clock share one synchroniser latency, so they stay aligned
  // as long as the link clock is well below sys_clk
  wire rx_rise = s_rx_clk & ~rx_clk_prev;
  // loopback source select
  // Loopback takes the transmitter's own nibbles; PHY receive pins are ignored
  wire src_stb = m_int_loop ? tx_nib_stb : rx_rise;
  wire src_dv = m_int_loop ? tx_en_in : s_rx_dv;
  wire src_er = m_int_loop ? 1'b0 : s_rx_er;
  wire [3:0] src_d = m_int_loop ? txd_in : s_rxd;
  wire frame_start = src_stb & src_dv & ~rx_in_frame;
  wire frame_end = src_stb & ~src_dv & rx_in_frame;
  // A false-carrier code outside a frame counts as an illegal carrier
  wire ill_carrier = src_stb & ~src_dv & src_er & (src_d == EMM_FALSE_CARRIER);

  // ------------------------------------------------------------------
  // Event and bus decode
  // ------------------------------------------------------------------
  // wake detection gated by enable
  wire wake_ev = wake_pattern_seen & m_wake_en;
  // The synchroniser and link_prev leave reset at zero while the pin
  // usually idles high; without a settling window the first cycles after
  // reset would report a link change that never happened. A real change
  // inside that window is missed, and no register lets software read the
  // link state itself.
  wire link_ev = (s_link ^ link_prev) & link_warm[EMM_LINK_SETTLE-1];
  wire [EMM_ST_W-1:0] st_set;
  assign st_set[EMM_ST_ILL_CARRIER] = ill_carrier;
  assign st_set[EMM_ST_WAKE] = wake_ev;
  assign st_set[EMM_ST_LINK_CHG] = link_ev;

  wire addr_phase = hsel & htrans[1] & hready;
  wire [7:0] ap_ofs = haddr[7:0];
  wire wr_mode = wr_pend & ofs_hit(wr_ofs, EMM_OFS_MODE);
  wire wr_int_en = wr_pend & ofs_hit(wr_ofs, EMM_OFS_INT_EN);
  wire wr_crc = wr_pend & ofs_hit(wr_ofs, EMM_OFS_CRC_CNT);
  // write-one clear through status or clear register
  wire wr_clr = wr_pend & (ofs_hit(wr_ofs, EMM_OFS_STATUS) | ofs_hit(wr_ofs, EMM_OFS_CLEAR));
  wire [EMM_ST_W-1:0] st_clr = wr_clr ? hwdata[EMM_ST_W-1:0] : '0;
  // New events win over a clear in the same cycle
  wire [EMM_ST_W-1:0] next_status = (status & ~st_clr) | st_set;

  // Frames that arrive while the receiver is off are not counted
  // bad-CRC frame is an error only when not permitted
  wire crc_counted = rx_crc_err & ~m_crc_permit & rx_run;
  // counter frozen while permitted; a write clear in the same cycle as an increment leaves one
  wire [CNT_W-1:0] next_crc_cnt = crc_counted ?
      (wr_crc ? CNT_W'(1) : crc_cnt + CNT_W'(1)) : (wr_crc ? '0 : crc_cnt);

  // Read data selection; unmapped offsets read as zero
  wire [31:0] rd_word =
      ofs_hit(ap_ofs, EMM_OFS_MODE) ? mode :
      ofs_hit(ap_ofs, EMM_OFS_STATUS) ? st_word(status) :
      ofs_hit(ap_ofs, EMM_OFS_INT_EN) ? st_word(int_en) :
      ofs_hit(ap_ofs, EMM_OFS_CRC_CNT) ? {{(32-CNT_W){1'b0}}, crc_cnt} : 32'h0000_0000;

  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------
  // Zero wait states: writes land in the data phase, reads are prepared
  // in the address phase so the data phase can return them at once
  // Trade-off: a read issued straight after a write to the same register
  // is captured before that write lands and returns the old value, so
  // software leaves one idle cycle between them
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_phase & hwrite;
      wr_ofs <= ap_ofs;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Mode and interrupt enable registers
  // Mode changes are taken as written; keeping fields still while the
  // enables are on, and pairing loopback with full duplex, is software's duty
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode <= EMM_MODE_RESET;
      int_en <= EMM_ST_RESET;
    end else begin
      if (wr_mode) begin
        mode <= hwdata & EMM_MODE_WR_MASK;
      end
      if (wr_int_en) begin
        int_en <= hwdata[EMM_ST_W-1:0];
      end
    end
  end

  // Sticky status, counter, wake pin and interrupt
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status <= EMM_ST_RESET;
      crc_cnt <= '0;
      wake_on_lan_output <= 1'b0;
      irq <= 1'b0;
      link_prev <= 1'b0;
      link_warm <= '0;
      rx_crc_fault <= 1'b0;
    end else begin
      status <= next_status;
      crc_cnt <= next_crc_cnt;
      link_prev <= s_link;
      link_warm <= {link_warm[EMM_LINK_SETTLE-2:0], 1'b1};
      rx_crc_fault <= crc_counted;
      wake_on_lan_output <= next_status[EMM_ST_WAKE];
      irq <= |(next_status & int_en);
    end
  end

  // ------------------------------------------------------------------
  // Receiver enable and nibble capture
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_clk_prev <= 1'b0;
      rx_in_frame <= 1'b0;
      rx_run <= 1'b0;
    end else begin
      rx_clk_prev <= s_rx_clk;
      if (frame_start) begin
        rx_in_frame <= 1'b1;
      end else if (frame_end) begin
        rx_in_frame <= 1'b0;
      end
      // enable follows the bit only between frames
      if (!rx_in_frame || frame_end) begin
        rx_run <= m_rx_en;
      end
    end
  end

  // Nibbles of a frame pass only while the receiver runs
  // A frame that began while the receive enable bit was clear is dropped whole
  // rather than delivered from its middle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_nib_valid <= 1'b0;
      rx_nib <= 4'h0;
      rx_nib_err <= 1'b0;
    end else begin
      rx_nib_valid <= src_stb & src_dv & rx_run & (rx_in_frame | m_rx_en);
      rx_nib <= src_d;
      rx_nib_err <= src_stb & src_dv & src_er;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_accept <= 1'b0;
    end else begin
      rx_accept <= rx_filter_valid & rx_run &
          (m_promisc | rx_addr_match | rx_bcast_hit | rx_mcast_hit);
    end
  end

  // ------------------------------------------------------------------
  // Transmitter enable and duplex
  // ------------------------------------------------------------------
  // A frame request is only taken while the transmitter runs, which lags its
  // enable bit by one cycle, so a request in the first cycle after a disable still starts a frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_in_frame <= 1'b0;
      tx_run <= 1'b0;
      full_duplex <= 1'b0;
      tx_collision <= 1'b0;
    end else begin
      // a frame started while the enable bit is set holds the transmitter on until done
      if (tx_frame_done) begin
        tx_in_frame <= 1'b0;
      end else if (tx_frame_req && tx_run) begin
        tx_in_frame <= 1'b1;
      end
      // transmitter follows its enable between frames
      if (!tx_in_frame || tx_frame_done) begin
        tx_run <= m_tx_en;
      end
      // duplex select; collisions matter only in half duplex
      full_duplex <= m_duplex;
      tx_collision <= s_col & ~m_duplex & tx_in_frame;
    end
  end

  // external loopback bit on the pin
  assign general_output_pin = mode[EMM_B_EXT_LOOP];

endmodule

// File: core/emm_pkg.sv
// Constants shared by the MAC mode-control block: register map, field
// positions, reset values and the link-side encodings.
// Assumes a 32-bit AHB-Lite register bus and a 4-bit media-independent link.
package emm_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] EMM_OFS_MODE = 8'h00;
  localparam logic [7:0] EMM_OFS_STATUS = 8'h04;
  localparam logic [7:0] EMM_OFS_INT_EN = 8'h08;
  localparam logic [7:0] EMM_OFS_CLEAR = 8'h0c;
  localparam logic [7:0] EMM_OFS_CRC_CNT = 8'h10;

  // ------------------------------------------------------------------
  // Mode-control fields
  // ------------------------------------------------------------------
  localparam int EMM_B_PROMISC = 0;
  localparam int EMM_B_DUPLEX = 1;
  localparam int EMM_B_EXT_LOOP = 2;
  localparam int EMM_B_INT_LOOP = 3;
  localparam int EMM_B_TX_EN = 5;
  localparam int EMM_B_RX_EN = 6;
  localparam int EMM_B_WAKE_EN = 9;
  localparam int EMM_B_CRC_PERMIT = 12;
  // Writable bits; all others are reserved and read as zero
  localparam logic [31:0] EMM_MODE_WR_MASK = 32'h0000_126f;
  localparam logic [31:0] EMM_MODE_RESET = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Status, interrupt enable and clear layout
  // ------------------------------------------------------------------
  localparam int EMM_ST_W = 3;
  localparam int EMM_ST_ILL_CARRIER = 0;
  localparam int EMM_ST_WAKE = 1;
  localparam int EMM_ST_LINK_CHG = 2;
  localparam logic [EMM_ST_W-1:0] EMM_ST_RESET = 3'h0;

  // ------------------------------------------------------------------
  // Link encodings and sizes
  // ------------------------------------------------------------------
  localparam logic [3:0] EMM_FALSE_CARRIER = 4'he;
  localparam int EMM_CNT_W = 16;
  localparam int EMM_SYNC_W = 9;
  // Cycles after reset before the link-status input is trusted
  localparam int EMM_LINK_SETTLE = 3;
  localparam logic [1:0] EMM_HTRANS_NONSEQ = 2'h2;

endpackage

// File: core/emm_sync.sv
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no word coherence across bits.
`timescale 1ns/100ps

module emm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: bench/emm_phy_model.sv
// PHY stand-in driving the receive pins of the media-independent link.
// Assumes the bench calls send_frame from one thread at a time.
`timescale 1ns/100ps

module emm_phy_model (
  // Receive pins
  output logic mii_rx_clk,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic [3:0] mii_rxd,
  // Status pins
  output logic mii_col,
  output logic link_status
);
  // Idle: clock stands still between frames, data lines never look valid
  initial begin
    mii_rx_clk = 1'b0;
    mii_rx_dv = 1'b0;
    mii_rx_er = 1'b0;
    mii_rxd = 4'h5;
    mii_col = 1'b0;
    link_status = 1'b1;
  end

  // One frame of n nibbles plus a closing sample with valid low
  task automatic send_frame(input int n);
    for (int i = 0; i <= n; i++) begin
      mii_rx_dv = (i < n);
      mii_rxd = (i < n) ? i[3:0] : ~mii_rxd;
      #160;
      mii_rx_clk = 1'b1;
      #160;
      mii_rx_clk = 1'b0;
    end
    mii_rxd = ~mii_rxd;
  endtask
endmodule

// File: bench/emm_mode_ctrl_properties.sv
// Port-level checker for the mode-control block.
// Assumes one clock, sys_clk, and a synchronous reset, sys_rst.
`timescale 1ns/100ps

module emm_chk
  import emm_pkg::*;
(
  // Clock and reset
  input logic sys_clk,
  input logic sys_rst,
  // Bus
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  // Events and pins in
  input logic tx_frame_req,
  input logic tx_frame_done,
  input logic wake_pattern_seen,
  input logic rx_filter_valid,
  input logic rx_addr_match,
  input logic rx_crc_err,
  input logic mii_rx_dv,
  // Outputs watched
  input logic rx_nib_valid,
  input logic rx_run,
  input logic tx_run,
  input logic rx_accept,
  input logic rx_crc_fault,
  input logic full_duplex,
  input logic general_output_pin,
  input logic wake_on_lan_output
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Helpers
  // ----
  logic wr_mode_d;
  logic wr_st_d;
  logic tx_busy;
  wire wr_take = hsel & htrans[1] & hready & hwrite;
  wire st_sel = (haddr[7:0] == EMM_OFS_STATUS) | (haddr[7:0] == EMM_OFS_CLEAR);
  // Data phase of a mode or status write
  always_ff @(posedge sys_clk) begin
    wr_mode_d <= !sys_rst & wr_take & (haddr[7:0] == EMM_OFS_MODE);
    wr_st_d <= !sys_rst & wr_take & st_sel;
  end
  // Frame in flight, so a late disable can be told from an early one
  always_ff @(posedge sys_clk) begin
    if (sys_rst | tx_frame_done) begin
      tx_busy <= 1'b0;
    end else if (tx_frame_req & tx_run) begin
      tx_busy <= 1'b1;
    end
  end
  // ----
  // Properties
  // ----
  // pin copies bit
  property p_pin; wr_mode_d |=> general_output_pin == $past(hwdata[2]); endproperty
  a_pin: assert property (p_pin) else $error("output pin off");
  property p_dup; wr_mode_d |=> ##1 full_duplex == $past(hwdata[1], 2); endproperty
  a_dup: assert property (p_dup) else $error("duplex off");
  property p_wrise;
    $rose(wake_on_lan_output) |-> $past(wake_pattern_seen) || $past(wake_pattern_seen, 2);
  endproperty
  a_wrise: assert property (p_wrise) else $error("wake pin rose alone");
  property p_wfall; $fell(wake_on_lan_output) |-> $past(wr_st_d) || $past(wr_st_d, 2); endproperty
  a_wfall: assert property (p_wfall) else $error("wake pin fell alone");
  property p_rxhold; mii_rx_dv[*8] ##1 mii_rx_dv[*6] |=> !$fell(rx_run); endproperty
  a_rxhold: assert property (p_rxhold) else $error("receiver stopped mid-frame");
  property p_txhold; $fell(tx_run) |-> !$past(tx_busy) || $past(tx_frame_done); endproperty
  a_txhold: assert property (p_txhold) else $error("transmitter stopped mid-frame");
  property p_acc; rx_accept |-> $past(rx_filter_valid) && $past(rx_run); endproperty
  a_acc: assert property (p_acc) else $error("accept without cause");
  property p_match; rx_filter_valid && rx_run && rx_addr_match |=> rx_accept; endproperty
  a_match: assert property (p_match) else $error("own frame dropped");
  property p_crc; rx_crc_fault |-> $past(rx_crc_err) && $past(rx_run); endproperty
  a_crc: assert property (p_crc) else $error("CRC fault without cause");
  property p_nib; rx_nib_valid |-> rx_run || $past(rx_run); endproperty
  a_nib: assert property (p_nib) else $error("nibble while off");
  c_wake: cover property ($rose(wake_on_lan_output));
  c_txoff: cover property ($fell(tx_run));
  c_acc: cover property (rx_accept);
endmodule

bind emm_mode_ctrl emm_chk u_chk (
  .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .tx_frame_req, .tx_frame_done, .wake_pattern_seen, .rx_filter_valid, .rx_addr_match,
  .rx_crc_err, .mii_rx_dv, .rx_nib_valid, .rx_run, .tx_run, .rx_accept, .rx_crc_fault,
  .full_duplex, .general_output_pin, .wake_on_lan_output
);

// File: bench/tb.sv
// Self-checking bench for the mode-control block over AHB-Lite.
// Assumes the checker binds itself and the PHY model drives the link pins.
`timescale 1ns/100ps

module tb
  import emm_pkg::*;
;
  // Longest frame on this link, in sys_clk cycles
  localparam int MAX_FRAME_CYC = 24400;
  logic sys_clk, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic tx_frame_req = 1'b0, tx_frame_done = 1'b0, tx_nib_stb = 1'b0, tx_en_in = 1'b0;
  logic [3:0] txd_in = 4'h0, mii_rxd, rx_nib;
  logic rx_crc_err = 1'b0, wake_pattern_seen = 1'b0, rx_filter_valid = 1'b0;
  logic rx_addr_match = 1'b0, rx_bcast_hit = 1'b0, rx_mcast_hit = 1'b0;
  logic mii_rx_clk, mii_rx_dv, mii_rx_er, mii_col, link_status, rx_nib_valid;
  logic rx_run, tx_run, full_duplex, rx_accept, general_output_pin, wake_on_lan_output, irq;
  logic rx_nib_err, hresp;
  int failures = 0;
  int samples_checked = 0;

  emm_phy_model phy (.mii_rx_clk, .mii_rx_dv, .mii_rx_er, .mii_rxd, .mii_col, .link_status);
  emm_mode_ctrl dut (
    .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .mii_rx_clk, .mii_rx_dv, .mii_rx_er, .mii_rxd, .mii_col, .link_status,
    .tx_frame_req, .tx_frame_done, .tx_nib_stb, .tx_en_in, .txd_in,
    .rx_crc_err, .wake_pattern_seen, .rx_filter_valid, .rx_addr_match, .rx_bcast_hit,
    .rx_mcast_hit, .rx_nib_valid, .rx_nib, .rx_nib_err, .rx_run, .tx_run, .full_duplex,
    .tx_collision(), .rx_accept, .rx_crc_fault(), .general_output_pin,
    .wake_on_lan_output, .irq
  );

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One single transfer; entered right after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= EMM_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Filter verdict lands one cycle after the strobe
  task automatic filt(input logic m, input logic e);
    rx_addr_match <= m;
    rx_filter_valid <= 1'b1;
    tick(1);
    rx_filter_valid <= 1'b0;
    tick(1);
    chk({31'h0, rx_accept}, {31'h0, e});
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    tick(5);
    sys_rst <= 1'b0;
    tick(1);
    rd(EMM_OFS_MODE, EMM_MODE_RESET);
    rd(8'h20, 32'h0);
    wr(EMM_OFS_MODE, ~EMM_MODE_WR_MASK);
    tick(1);
    rd(EMM_OFS_MODE, 32'h0);
    wake_pattern_seen <= 1'b1;
    tick(1);
    wake_pattern_seen <= 1'b0;
    rd(EMM_OFS_STATUS, 32'h0);
    // Fields set from the disabled state, enables with them
    wr(EMM_OFS_MODE, 32'h0000_0266);
    tick(2);
    chk({31'h0, general_output_pin}, 32'h1);
    chk({31'h0, full_duplex}, 32'h1);
    chk({30'h0, rx_run, tx_run}, 32'h3);
    wake_pattern_seen <= 1'b1;
    tick(1);
    wake_pattern_seen <= 1'b0;
    tick(2);
    chk({30'h0, wake_on_lan_output, irq}, 32'h2);
    rd(EMM_OFS_STATUS, 32'h2);
    wr(EMM_OFS_INT_EN, 32'h2);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wr(EMM_OFS_STATUS, 32'h0);
    rd(EMM_OFS_STATUS, 32'h2);
    wr(EMM_OFS_STATUS, 32'h2);
    tick(1);
    rd(EMM_OFS_STATUS, 32'h0);
    tick(1);
    chk({30'h0, wake_on_lan_output, irq}, 32'h0);
    rx_crc_err <= 1'b1;
    tick(1);
    rx_crc_err <= 1'b0;
    rd(EMM_OFS_CRC_CNT, 32'h1);
    filt(1'b0, 1'b0);
    filt(1'b1, 1'b1);
    tx_frame_req <= 1'b1;
    tick(1);
    tx_frame_req <= 1'b0;
    wr(EMM_OFS_MODE, 32'h0000_0246);
    tick(2);
    chk({31'h0, tx_run}, 32'h1);
    tx_frame_done <= 1'b1;
    tick(1);
    tx_frame_done <= 1'b0;
    tick(2);
    chk({31'h0, tx_run}, 32'h0);
    fork
      phy.send_frame(20);
      begin
        tick(60);
        wr(EMM_OFS_MODE, 32'h0000_0206);
        tick(2);
        chk({31'h0, rx_run}, 32'h1);
      end
    join
    tick(8);
    chk({31'h0, rx_run}, 32'h0);
    // Both enables off: let any frame drain before other fields move
    tick(MAX_FRAME_CYC);
    wr(EMM_OFS_MODE, 32'h0000_100b);
    wr(EMM_OFS_MODE, 32'h0000_106b);
    tick(2);
    rx_crc_err <= 1'b1;
    tick(1);
    rx_crc_err <= 1'b0;
    rd(EMM_OFS_CRC_CNT, 32'h1);
    filt(1'b0, 1'b1);
    tx_en_in <= 1'b1;
    txd_in <= 4'ha;
    tx_nib_stb <= 1'b1;
    tick(1);
    tx_nib_stb <= 1'b0;
    for (int i = 0; i < 12 && rx_nib_valid !== 1'b1; i++) tick(1);
    chk({31'h0, rx_nib_valid}, 32'h1);
    chk({27'h0, rx_nib_err, rx_nib}, 32'ha);
    finish_test();
  end

  // Watchdog well past the expected run length
  initial begin
    #1600000;
    failures++;
    finish_test();
  end
endmodule
